// File: rtl/sor_router.sv
// Servo status signal router with APB registers, safety monitor and pulse outputs
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// How it works
// (RQ1) Selector 1, 2 or 3 routes a status signal to pin 1-3; 0 unroutes it.
// (RQ2) Nine status signals each own an independent pin selector.
// (RQ3) Each of the three pins has its own inversion bit; 1 inverts the level.
// (RQ4) All inversion bits are cleared after reset.
// (RQ5) Safety monitor is on only while both redundant inputs are healthy; the code turns it on whenever the two inputs agree, high or low.
// (RQ6) Safety monitor follows any input change within 20 ms.
// (RQ7) Sink wiring reads low as ON, source wiring high as ON; open is OFF.
// (RQ8) Encoder position becomes differential quadrature and origin pulses.
// (RQ9) Several signals on one pin combine by logical OR.
// (RQ10) A signal meaningless in the current control mode reads inactive.
// (RQ11) Settings are clocked; pins update on the edge after a change.
module sor_router import sor_pkg::*; #(
  parameter int FILT = FILT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive status
  input wire sor_stat_t stat_in,
  input wire logic servo_alarm_in,
  // Sequence inputs
  input wire logic [NUM_IN-1:0] seq_in_raw,
  output logic [NUM_IN-1:0] seq_in_on,
  // Safety inputs and monitor
  input wire logic base_block_in_1,
  input wire logic base_block_in_2,
  output logic safety_monitor_out,
  // Encoder position and pulse outputs
  input wire sor_enc_t enc_in,
  output sor_diff_t quad_phase_a,
  output sor_diff_t quad_phase_b,
  output sor_diff_t origin_pulse,
  // Sequence outputs
  output logic [NUM_PIN-1:0] seq_out,
  output logic servo_alarm_out,
  // Interrupt
  output logic irq
);
  // ==================================================
  // Helpers
  // One-hot pin mask for a selector value; 0 maps to no pin
  function automatic logic [NUM_PIN-1:0] pin_dec(input logic [SEL_W-1:0] sel);
    logic [NUM_PIN-1:0] m;
    m = 3'h0;
    case (sel)
      2'h1: m = 3'h1;
      2'h2: m = 3'h2;
      2'h3: m = 3'h4;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

  // ==================================================
  // State
  logic [7:0] route_a_ff;
  logic [7:0] route_b_ff;
  logic [1:0] route_c_ff;
  logic [2:0] invert_ff;
  sor_mode_t mode_ff;
  logic src_ff;
  logic [NUM_EVT-1:0] int_ff;
  logic [NUM_EVT-1:0] mask_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic [NUM_PIN-1:0] seq_out_ff;
  logic [NUM_IN-1:0] seq_in_ff;
  logic alarm_ff;
  logic mon_d_ff;

  // ==================================================
  // APB decode
  logic setup;
  logic wr_en;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_inv;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_ist;
  logic hit_msk;
  logic mapped;
  logic [31:0] rd_mux;
  logic [2:0] nxt_mode;

  // Address match for each register
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign hit_a = (paddr == OFS_ROUTE_A);
  assign hit_b = (paddr == OFS_ROUTE_B);
  assign hit_c = (paddr == OFS_ROUTE_C);
  assign hit_inv = (paddr == OFS_INVERT);
  assign hit_ctrl = (paddr == OFS_CTRL);
  assign hit_stat = (paddr == OFS_STATUS);
  assign hit_ist = (paddr == OFS_INT_STAT);
  assign hit_msk = (paddr == OFS_INT_MASK);
  assign mapped = hit_a | hit_b | hit_c | hit_inv | hit_ctrl | hit_stat | hit_ist | hit_msk;

  // Read mux; unused bits read as zero
  assign rd_mux = hit_a ? {24'h0, route_a_ff} :
                  hit_b ? {24'h0, route_b_ff} :
                  hit_c ? {30'h0, route_c_ff} :
                  hit_inv ? {29'h0, invert_ff} :
                  hit_ctrl ? {28'h0, src_ff, mode_ff} :
                  hit_stat ? {16'h0, seq_in_ff, 3'h0, alarm_ff, safety_monitor_out, seq_out_ff} :
                  hit_ist ? {29'h0, int_ff} :
                  hit_msk ? {29'h0, mask_ff} : 32'h0;

  // Data is captured in the setup cycle so the access cycle always completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0;
      err_ff <= 1'b0;
    end else if (setup) begin
      rdata_ff <= rd_mux;
      err_ff <= !mapped;
    end
  end
  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_ff;

  // ==================================================
  // Settings registers
  // A mode write with no valid one-hot code keeps the old mode
  assign nxt_mode = (pwdata[2:0] == MODE_POS || pwdata[2:0] == MODE_SPD || pwdata[2:0] == MODE_TRQ) ?
                    pwdata[2:0] : mode_ff;

  // (RQ11) clocked settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_a_ff <= ROUTE_RST;
      route_b_ff <= ROUTE_RST;
      route_c_ff <= ROUTE_RST[1:0];
      // (RQ4) inversion cleared
      invert_ff <= INVERT_RST;
      mode_ff <= MODE_POS;
      src_ff <= 1'b0;
      mask_ff <= MASK_RST;
    end else if (wr_en) begin
      if (hit_a) route_a_ff <= pwdata[7:0];
      if (hit_b) route_b_ff <= pwdata[7:0];
      if (hit_c) route_c_ff <= pwdata[1:0];
      if (hit_inv) invert_ff <= pwdata[2:0];
      if (hit_ctrl) mode_ff <= sor_mode_t'(nxt_mode);
      if (hit_ctrl) src_ff <= pwdata[CTRL_SRC_BIT];
      if (hit_msk) mask_ff <= pwdata[NUM_EVT-1:0];
    end
  end

  // ==================================================
  // Signal routing
  logic [2*NUM_SIG-1:0] sel_all;
  sor_stat_t gated;
  logic [NUM_PIN-1:0][NUM_SIG-1:0] pin_hits;
  logic [NUM_PIN-1:0] pin_or;
  logic [NUM_PIN-1:0] nxt_seq_out;

  // (RQ2) one selector per signal
  assign sel_all = {route_c_ff, route_b_ff, route_a_ff};

  // (RQ10) mode validity gate
  // Positioning done only means something in position mode, speed match in speed mode
  assign gated = stat_in & ~sor_stat_t'({7'h0, mode_ff != MODE_SPD, mode_ff != MODE_POS});

  // (RQ1) selector decode
  for (genvar i = 0; i < NUM_SIG; i++) begin : g_sig
    logic [NUM_PIN-1:0] m;
    assign m = pin_dec(sel_all[2*i +: 2]);
    for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
      assign pin_hits[p][i] = m[p] & gated[i];
    end
  end

  // (RQ9) OR merge per pin
  for (genvar p = 0; p < NUM_PIN; p++) begin : g_or
    assign pin_or[p] = |pin_hits[p];
  end

  // (RQ3) per-pin inversion
  assign nxt_seq_out = pin_or ^ invert_ff;

  // Registered pins give clean edges to the photocoupler stage
  // (RQ11) update next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_out_ff <= 3'h0;
      alarm_ff <= 1'b0;
    end else begin
      seq_out_ff <= nxt_seq_out;
      alarm_ff <= servo_alarm_in;
    end
  end
  assign seq_out = seq_out_ff;
  assign servo_alarm_out = alarm_ff;

  // ==================================================
  // Sequence input sense
  logic [NUM_IN-1:0] nxt_seq_in;

  // (RQ7) sink or source sense
  // Sink: low level is ON; source: high level is ON; open contact is OFF either way
  assign nxt_seq_in = src_ff ? seq_in_raw : ~seq_in_raw;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_in_ff <= 8'h0;
    end else begin
      seq_in_ff <= nxt_seq_in;
    end
  end
  assign seq_in_on = seq_in_ff;

  // ==================================================
  // Safety monitor and pulse outputs
  sor_safety_mon #(
    .FILT(FILT)
  ) u_safety (
    .pclk(pclk),
    .presetn(presetn),
    .base_block_in_1(base_block_in_1),
    .base_block_in_2(base_block_in_2),
    .safety_monitor_out(safety_monitor_out)
  );

  sor_quad_gen u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .enc_in(enc_in),
    .quad_phase_a(quad_phase_a),
    .quad_phase_b(quad_phase_b),
    .origin_pulse(origin_pulse)
  );

  // ==================================================
  // Interrupts
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] clr;
  logic [NUM_EVT-1:0] nxt_int;

  // Events: monitor drop, monitor rise, any sequence pin change
  assign evt[EVT_MON_FALL] = mon_d_ff && !safety_monitor_out;
  assign evt[EVT_MON_RISE] = !mon_d_ff && safety_monitor_out;
  assign evt[EVT_PIN_CHG] = |(nxt_seq_out ^ seq_out_ff);
  assign clr = (wr_en && hit_ist) ? pwdata[NUM_EVT-1:0] : 3'h0;
  // A new event in the clearing cycle survives the clear
  assign nxt_int = (int_ff & ~clr) | evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ff <= 3'h0;
      mon_d_ff <= 1'b0;
    end else begin
      int_ff <= nxt_int;
      mon_d_ff <= safety_monitor_out;
    end
  end
  assign irq = |(int_ff & mask_ff);

  // ==================================================
  // Checks
  chk_route_pin_one: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (stat_in.rotating && route_a_ff[5:4] == 2'h1 && !invert_ff[0]) |=> seq_out[0])
    else $error("routed signal missing on pin 1");
  chk_unrouted_idle: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (route_a_ff == 8'h0 && route_b_ff == 8'h0 && route_c_ff == 2'h0) |=> seq_out == $past(invert_ff))
    else $error("pin active with nothing routed");
  chk_invert_flip: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (invert_ff[1] && !pin_or[1]) |=> seq_out[1])
    else $error("inverted idle pin not high");
  chk_invert_reset: assert property (@(posedge pclk) // RQ4
    $rose(presetn) |-> invert_ff == 3'h0)
    else $error("inversion not cleared by reset");
  chk_or_merge: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (route_b_ff[7:6] == 2'h3 && route_c_ff == 2'h3 && (stat_in.warning || stat_in.near_zone) && !invert_ff[2])
    |=> seq_out[2])
    else $error("pin 3 lost an OR input");
  chk_mode_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (mode_ff != MODE_POS && route_a_ff == 8'h01 && route_b_ff == 8'h0 && route_c_ff == 2'h0 && !invert_ff[0])
    |=> !seq_out[0])
    else $error("positioning done leaked outside position mode");
  chk_sense_sink: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (!src_ff && !seq_in_raw[0]) |=> seq_in_on[0])
    else $error("sink low level not read as on");
  chk_pin_update: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (wr_en && hit_inv) |=> ##1 seq_out == ($past(pin_or) ^ $past(pwdata[2:0], 2)))
    else $error("pins did not follow new inversion");

  // ==================================================
  // Further checks on bus, interrupts and pins

  // (RQ11) settings hold between writes
  chk_setting_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    !(wr_en && hit_inv) |=> $stable(invert_ff))
    else $error("inversion changed without a write");

  // Unmapped access answers with an error
  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // bus error
    (psel && penable && !mapped) |-> pslverr)
    else $error("unmapped access without error");

  // Set beats a clear in the same cycle
  chk_int_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // sticky flag
    evt[EVT_MON_FALL] |=> int_ff[EVT_MON_FALL])
    else $error("monitor drop not recorded");

  // Writing one clears a quiet flag
  chk_int_w1c: assert property (@(posedge pclk) disable iff (!presetn) // sticky flag
    (wr_en && hit_ist && pwdata[EVT_MON_FALL] && !evt[EVT_MON_FALL]) |=> !int_ff[EVT_MON_FALL])
    else $error("flag survived its clear");

  // Any pin change raises its flag
  chk_pin_event: assert property (@(posedge pclk) disable iff (!presetn) // sticky flag
    (nxt_seq_out != seq_out_ff) |=> int_ff[EVT_PIN_CHG])
    else $error("pin change not recorded");

  // (RQ1) pin two routing
  chk_route_pin_two: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (stat_in.speed_limited && route_b_ff[3:2] == 2'h2 && !invert_ff[1]) |=> seq_out[1])
    else $error("routed signal missing on pin 2");

  // (RQ7) source sense level
  chk_sense_source: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (src_ff && seq_in_raw[0]) |=> seq_in_on[0])
    else $error("source high level not read as on");

  // Alarm is a one-cycle copy
  chk_alarm_copy: assert property (@(posedge pclk) disable iff (!presetn) // alarm path
    1'b1 |=> servo_alarm_out == $past(servo_alarm_in))
    else $error("alarm output lost its input");

  // Refused mode codes never land
  chk_mode_legal: assert property (@(posedge pclk) disable iff (!presetn) // mode refusal
    mode_ff == MODE_POS || mode_ff == MODE_SPD || mode_ff == MODE_TRQ)
    else $error("mode register holds an illegal code");

  // (RQ3) pin three inversion
  chk_invert_pin_three: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (invert_ff[2] && pin_or[2]) |=> !seq_out[2])
    else $error("inverted active pin not low");

  // (RQ9) pin one OR merge
  chk_or_pin_one: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (route_a_ff[5:4] == 2'h1 && route_a_ff[7:6] == 2'h1 && (stat_in.rotating || stat_in.servo_ready) &&
     !invert_ff[0]) |=> seq_out[0])
    else $error("pin 1 lost an OR input");
endmodule // sor_router

// File: rtl/sor_pkg.sv
// Shared constants and types for the servo output signal router
package sor_pkg;
  // ==================================================
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int FILT_TIME_US = 1000;
  localparam int FILT_CYC = FILT_TIME_US * CLK_MHZ;
  localparam int MON_MAX_MS = 20;
  localparam int MON_MAX_CYC = MON_MAX_MS * 1000 * CLK_MHZ;
  // ==================================================
  // Sizes
  localparam int NUM_SIG = 9;
  localparam int NUM_PIN = 3;
  localparam int NUM_IN = 8;
  localparam int NUM_EVT = 3;
  localparam int SEL_W = 2;
  localparam int ORG_W = 12;
  // ==================================================
  // Register byte offsets
  localparam logic [7:0] OFS_ROUTE_A = 8'h00;
  localparam logic [7:0] OFS_ROUTE_B = 8'h04;
  localparam logic [7:0] OFS_ROUTE_C = 8'h08;
  localparam logic [7:0] OFS_INVERT = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1c;
  // ==================================================
  // Reset values and field positions
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [2:0] INVERT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int CTRL_SRC_BIT = 3;
  localparam int EVT_MON_FALL = 0;
  localparam int EVT_MON_RISE = 1;
  localparam int EVT_PIN_CHG = 2;
  // ==================================================
  // Types
  typedef enum logic [2:0] {
    MODE_POS = 3'b001,
    MODE_SPD = 3'b010,
    MODE_TRQ = 3'b100
  } sor_mode_t;
  typedef struct packed {
    logic near_zone;
    logic warning;
    logic brake_release;
    logic speed_limited;
    logic torque_limited;
    logic servo_ready;
    logic rotating;
    logic speed_match;
    logic position_done;
  } sor_stat_t;
  typedef struct packed {
    logic [15:0] pos;
    logic valid;
  } sor_enc_t;
  typedef struct packed {
    logic p;
    logic n;
  } sor_diff_t;
endpackage

// File: rtl/sor_safety_mon.sv
// Safety monitor for the two redundant base-block inputs
`timescale 1ns/1ps
module sor_safety_mon import sor_pkg::*; #(
  parameter int FILT = FILT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Redundant inputs
  input wire logic base_block_in_1,
  input wire logic base_block_in_2,
  // Monitor
  output logic safety_monitor_out
);
  logic [19:0] cnt_ff;
  logic mon_ff;
  logic agree;
  logic [19:0] nxt_cnt;
  logic nxt_mon;
  logic [20:0] lat_ff;

  // ==================================================
  // Agreement filter
  // Turn-on waits for a stable agreement; turn-off is immediate for safety
  assign agree = (base_block_in_1 == base_block_in_2);
  assign nxt_cnt = !agree ? 20'h0 : (cnt_ff >= 20'(FILT)) ? cnt_ff : cnt_ff + 20'h1;
  // (RQ5) both inputs agree, both high or both low
  assign nxt_mon = agree && (cnt_ff >= 20'(FILT));
  // (RQ6) bounded reaction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 20'h0;
      mon_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      mon_ff <= nxt_mon;
    end
  end
  assign safety_monitor_out = mon_ff;

  // Cycles the monitor lags behind a healthy pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_ff <= 21'h0;
    end else begin
      lat_ff <= (agree && !mon_ff) ? lat_ff + 21'h1 : 21'h0;
    end
  end
  chk_mon_drop_fast: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    !agree |=> !safety_monitor_out) else $error("monitor stayed on with split inputs");
  chk_mon_latency_bound: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    lat_ff < 21'(MON_MAX_CYC)) else $error("monitor slower than limit");
endmodule // sor_safety_mon

// File: rtl/sor_quad_gen.sv
// Quadrature pulse and origin pulse generator from encoder position words
`timescale 1ns/1ps
module sor_quad_gen import sor_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Encoder position
  input wire sor_enc_t enc_in,
  // Differential outputs
  output sor_diff_t quad_phase_a,
  output sor_diff_t quad_phase_b,
  output sor_diff_t origin_pulse
);
  logic [15:0] tgt_ff;
  logic [15:0] cnt_ff;
  sor_diff_t a_ff;
  sor_diff_t b_ff;
  sor_diff_t z_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] diff;

  // ==================================================
  // Step one count per cycle toward the latest position, never skipping a phase
  assign diff = tgt_ff - cnt_ff;
  assign nxt_cnt = (diff == 16'h0) ? cnt_ff : diff[15] ? cnt_ff - 16'h1 : cnt_ff + 16'h1;
  // (RQ8) pulse conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_ff <= 16'h0;
      cnt_ff <= 16'h0;
      a_ff <= '{p: 1'b0, n: 1'b1};
      b_ff <= '{p: 1'b0, n: 1'b1};
      z_ff <= '{p: 1'b0, n: 1'b1};
    end else begin
      if (enc_in.valid) tgt_ff <= enc_in.pos;
      cnt_ff <= nxt_cnt;
      a_ff <= '{p: nxt_cnt[1], n: ~nxt_cnt[1]};
      b_ff <= '{p: nxt_cnt[1] ^ nxt_cnt[0], n: ~(nxt_cnt[1] ^ nxt_cnt[0])};
      z_ff <= '{p: nxt_cnt[ORG_W-1:0] == '0, n: nxt_cnt[ORG_W-1:0] != '0};
    end
  end
  assign quad_phase_a = a_ff;
  assign quad_phase_b = b_ff;
  assign origin_pulse = z_ff;

  chk_quad_pair_diff: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    (a_ff.p != a_ff.n) && (b_ff.p != b_ff.n) && (z_ff.p != z_ff.n)) else $error("pair not differential");
endmodule // sor_quad_gen

// File: tb/sor_host_model.sv
// Host controller model: relays on the sequence outputs, contacts on the sequence inputs
`timescale 1ns/1ps
module sor_host_model import sor_pkg::*; (
  // Clock
  input wire logic pclk,
  // Sequence outputs of the drive
  input wire logic [NUM_PIN-1:0] seq_out,
  output logic [NUM_PIN-1:0] relay_on,
  // Contacts toward the drive inputs
  input wire logic [NUM_IN-1:0] contact_closed,
  input wire logic source_wiring,
  output logic [NUM_IN-1:0] seq_in_raw
);
  // ==================================================
  // Relay coils pick up the pin level one clock later
  always_ff @(posedge pclk) begin
    relay_on <= seq_out;
  end
  // sink or source wiring
  // An open contact floats to the idle level of the chosen wiring, never to a held value
  assign seq_in_raw = source_wiring ? contact_closed : ~contact_closed;
endmodule // sor_host_model

// File: tb/testbench.sv
// Self-checking bench for the servo output signal router
`timescale 1ns/1ps
module testbench;
  import sor_pkg::*;
  localparam int LIMIT = 30000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, alarm = 1'b0, bb1 = 1'b0, bb2 = 1'b0, src = 1'b0, irq, mon, alarm_out;
  sor_stat_t stat_in = '0;
  sor_enc_t enc_in = '0;
  sor_diff_t qa, qb, qo;
  logic [NUM_IN-1:0] raw, on, contacts = 8'h00;
  logic [NUM_PIN-1:0] seq_out, relay;
  logic [17:0] sel;
  logic [2:0] inv, mode;
  logic prev_a;
  int fails = 0, check_count = 0, cyc = 0, toggles;
  // ==================================================
  // Clock, design and host model
  always #10 pclk = ~pclk;
  sor_router #(.FILT(4)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stat_in(stat_in),
    .servo_alarm_in(alarm), .seq_in_raw(raw), .seq_in_on(on), .base_block_in_1(bb1), .base_block_in_2(bb2),
    .safety_monitor_out(mon), .enc_in(enc_in), .quad_phase_a(qa), .quad_phase_b(qb), .origin_pulse(qo),
    .seq_out(seq_out), .servo_alarm_out(alarm_out), .irq(irq));
  sor_host_model host (.pclk(pclk), .seq_out(seq_out), .relay_on(relay), .contact_closed(contacts),
    .source_wiring(src), .seq_in_raw(raw));
  // ==================================================
  // Reporting and hang guard
  task automatic final_report;
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      final_report;
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // ==================================================
  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected pin levels: OR of the routed, mode-valid signals, then per-pin inversion
  function automatic logic [2:0] exp_pins(logic [17:0] s, sor_stat_t st, logic [2:0] iv, logic [2:0] md);
    logic [8:0] v;
    logic [2:0] p;
    v = st;
    p = 3'h0;
    if (md != MODE_POS) v[0] = 1'b0;
    if (md != MODE_SPD) v[1] = 1'b0;
    for (int i = 0; i < NUM_SIG; i++) begin
      if (s[2*i+:2] != 2'h0) p[s[2*i+:2]-1] = p[s[2*i+:2]-1] | v[i];
    end
    return p ^ iv;
  endfunction
  // ==================================================
  // Main sequence
  initial begin
    void'($urandom(76253));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_INVERT, 32'h0);
    chk("invert_reset", 32'h0, rd);
    chk("pins_reset", 32'h0, {29'h0, seq_out});
    // Random routing, inversion, mode and status, with fixed corner cases first
    for (int t = 0; t < 60; t++) begin
      sel = (t == 0) ? 18'h0 : (t == 1) ? 18'h15555 : (t == 2) ? 18'h3ffff : (t == 3) ? 18'h00001 : 18'($urandom);
      inv = (t < 4) ? 3'h7 * 3'(t == 1) : 3'($urandom);
      // Corner 3 routes only positioning done, in speed mode, so the mode gate is exercised
      case ((t == 3) ? 1 : $urandom % 3)
        0: mode = MODE_POS;
        1: mode = MODE_SPD;
        default: mode = MODE_TRQ;
      endcase
      apb(1'b1, OFS_ROUTE_A, {24'h0, sel[7:0]});
      apb(1'b1, OFS_ROUTE_B, {24'h0, sel[15:8]});
      apb(1'b1, OFS_ROUTE_C, {30'h0, sel[17:16]});
      apb(1'b1, OFS_INVERT, {29'h0, inv});
      apb(1'b1, OFS_CTRL, {29'h0, mode});
      @(posedge pclk);
      stat_in <= (t == 1) ? sor_stat_t'(9'h1ff) : sor_stat_t'($urandom);
      alarm <= 1'($urandom);
      repeat (3) @(posedge pclk);
      chk("seq_out", {29'h0, exp_pins(sel, stat_in, inv, mode)}, {29'h0, seq_out});
      chk("relay_on", {29'h0, exp_pins(sel, stat_in, inv, mode)}, {29'h0, relay});
      chk("alarm_out", {31'h0, alarm}, {31'h0, alarm_out});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status_pins", {29'h0, exp_pins(sel, stat_in, inv, mode)}, {29'h0, rd[2:0]});
    end
    // Invalid mode code keeps the last mode
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("mode_kept", {29'h0, mode}, {29'h0, rd[2:0]});
    // Unmapped address: read zero with an error response
    apb(1'b1, 8'h20, 32'hffffffff);
    chk("unmapped_wr_err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_rd", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    // Sequence input sense, sink then source wiring
    for (int w = 0; w < 2; w++) begin
      src <= w[0];
      contacts <= 8'($urandom);
      apb(1'b1, OFS_CTRL, {28'h0, w[0], 3'(MODE_POS)});
      repeat (3) @(posedge pclk);
      chk("seq_in_on", {24'h0, contacts}, {24'h0, on});
    end
    // Safety monitor and its interrupt
    bb1 <= 1'b1;
    bb2 <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("monitor_agree", 32'h1, {31'h0, mon});
    apb(1'b1, OFS_INT_STAT, 32'h7);
    apb(1'b1, OFS_INT_MASK, 32'h1);
    @(posedge pclk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    bb2 <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("monitor_disagree", 32'h0, {31'h0, mon});
    repeat (2) @(posedge pclk);
    chk("irq_fall", 32'h1, {31'h0, irq});
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk("int_stat_fall", 32'h1, {31'h0, rd[0]});
    apb(1'b1, OFS_INT_MASK, 32'h0);
    @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_INT_STAT, 32'h1);
    apb(1'b1, OFS_INT_MASK, 32'h1);
    @(posedge pclk);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    bb1 <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("monitor_both_off", 32'h1, {31'h0, mon});
    // Quadrature outputs stay complementary and phase A toggles
    enc_in <= '{pos: 16'h0040, valid: 1'b1};
    @(posedge pclk);
    enc_in.valid <= 1'b0;
    toggles = 0;
    prev_a = 1'b0;
    for (int c = 0; c < 80; c++) begin
      @(posedge pclk);
      if (c > 0 && qa.p !== prev_a) toggles++;
      prev_a = qa.p;
      chk("diff_pairs", 32'h7, {29'h0, qa.p ^ qa.n, qb.p ^ qb.n, qo.p ^ qo.n});
    end
    // Count walks 0 to 64 one step a cycle: phase A toggles every second step
    chk("phase_a_moves", 32'h20, 32'(toggles));
    final_report;
  end
endmodule // testbench
